// ==== verilog/nmcs_pkg.sv ====
// Constants, offsets and types of the manual-cycle and status block.
// Assumes a 40 MHz clock and a 32-bit AXI4-Lite master.
// Notes on behaviour
// - Extended address word holds bytes five-eight.
// - Over four bytes, extended write launches address.
// - Reading read port runs one flash read.
// - Upper data byte used only in wide mode.
// - Writing write port runs one flash write.
// - Single write bypasses the block datapath.
// - Status bit 18 shows write in progress.
// - Status bit 17 shows address in progress.
// - Status bit 16 shows command in progress.
// - Error results kept per 256-byte block.
// - Bits 15-8 flag uncorrectable block errors.
// - Bits 7-0 flag correctable block errors.
// - Block flags only follow simple ECC mode.
// - Result gives byte offset and bit position.
package nmcs_pkg;
  // ==========================================================
  // Register offsets.
  localparam logic [7:0] OFF_UPPER   = 8'h20;
  localparam logic [7:0] OFF_READ    = 8'h24;
  localparam logic [7:0] OFF_WRITE   = 8'h28;
  localparam logic [7:0] OFF_STATUS  = 8'h2c;
  localparam logic [3:0] OFF_RES_HI  = 4'h3;
  localparam logic [7:0] OFF_CTRL    = 8'h60;
  localparam logic [7:0] OFF_IRQST   = 8'h64;
  localparam logic [7:0] OFF_IRQMASK = 8'h68;
  // ==========================================================
  // Field positions and reset values.
  localparam int         ST_WR_PEND   = 18;
  localparam int         ST_ADDR_PEND = 17;
  localparam int         ST_CMD_PEND  = 16;
  localparam int         CTRL_WIDE    = 8;
  localparam int         CTRL_ECC     = 9;
  localparam logic [2:0] BYTES_RST    = 3'h4;
  localparam logic [2:0] BYTES_BASE   = 3'h3;
  localparam logic       ECC_RST      = 1'b1;
  localparam int         EV_CMD       = 0;
  localparam int         EV_ADDR      = 1;
  localparam int         EV_WR        = 2;
  localparam int         EV_RD        = 3;
  localparam int         EV_ECC       = 4;
  localparam int         NUM_EV       = 5;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // ==========================================================
  // Flash strobe timing.
  localparam int         CLK_NS       = 25;
  localparam int         T_PULSE_NS   = 50;
  localparam int         T_HOLD_NS    = 25;
  localparam logic [3:0] PULSE_CYC    =
    4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC     =
    4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  // ==========================================================
  // Flash cycle kinds.
  typedef enum logic [2:0] {
    OP_IDLE, OP_CMD, OP_ADDR, OP_WR, OP_RD
  } nmcs_op_t;
endpackage : nmcs_pkg

// ==== verilog/nmcs_top.sv ====
// Manual flash cycles, extended address and cycle/ECC status.
// Assumes an AXI4-Lite master on clk, command and base address
// pulses and ECC block results from logic on the same clock.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
module nmcs_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cmdLaunch,
  input  wire logic [7:0]  cmdByte,
  input  wire logic        baseAddrWrite,
  input  wire logic [31:0] baseAddr,
  input  wire logic        eccPageStart,
  input  wire logic        eccBlockDone,
  input  wire logic [2:0]  eccBlockIdx,
  input  wire logic        eccCorrectable,
  input  wire logic        eccUncorrectable,
  input  wire logic [7:0]  eccErrByte,
  input  wire logic [2:0]  eccErrBit,
  output logic             flashCle,
  output logic             flashAle,
  output logic             flashWeN,
  output logic             flashReN,
  output logic [15:0]      flashDataOut,
  output logic             flashDataOe,
  input  wire logic [15:0] flashDataIn,
  output logic             irq
);
  localparam int NUM_EV_W = nmcs_pkg::NUM_EV;

  // ==========================================================
  // State record.
  typedef struct packed {
    logic                  wRdy;
    logic                  bValid;
    logic [1:0]            bResp;
    logic                  arRdy;
    logic                  rValid;
    logic [1:0]            rResp;
    logic [31:0]           rData;
    logic [31:0]           upper;
    logic [31:0]           base;
    logic [7:0]            cmd;
    logic [2:0]            bytesM1;
    logic                  wide;
    logic                  eccSimple;
    logic [NUM_EV_W-1:0]   irqSt;
    logic [NUM_EV_W-1:0]   irqMask;
    logic [7:0]            uncor;
    logic [7:0]            corr;
    logic [7:0][10:0]      result;
    logic                  rdWait;
    logic                  rdBusy;
    logic                  wrWait;
    logic                  wrIsData;
    logic [15:0]           wrData;
    nmcs_pkg::nmcs_op_t    op;
    logic                  strobe;
    logic [3:0]            cnt;
    logic [2:0]            idx;
    logic                  cle;
    logic                  ale;
    logic                  weN;
    logic                  reN;
    logic [15:0]           dout;
    logic                  doe;
    logic [15:0]           dinS1;
    logic [15:0]           dinS2;
    logic                  irq;
  } nmcs_state_t;

  localparam nmcs_state_t RST_STATE = '{
    op:        nmcs_pkg::OP_IDLE,
    weN:       1'b1,
    reN:       1'b1,
    bytesM1:   nmcs_pkg::BYTES_RST,
    eccSimple: nmcs_pkg::ECC_RST,
    default:   '0
  };

  nmcs_state_t        s;
  nmcs_state_t        n;
  logic               go;
  nmcs_pkg::nmcs_op_t goOp;
  logic [15:0]        goVal;
  logic [NUM_EV_W-1:0] evt;

  // Picks address byte i of the eight-byte address series.
  function automatic logic [7:0] nmcs_byte(
    input logic [63:0] a,
    input logic [2:0]  i
  );
    nmcs_byte = a[{i, 3'h0} +: 8];
  endfunction : nmcs_byte

  // ==========================================================
  // Next-state logic for bus, registers and flash sequencer.
  always_comb
  begin
    n = s;
    go = 1'b0;
    goOp = nmcs_pkg::OP_IDLE;
    goVal = 16'h0000;
    evt = '0;
    n.bValid = s.bValid & ~s_axi_bready;
    n.rValid = s.rValid & ~s_axi_rready;
    n.dinS1 = flashDataIn;
    n.dinS2 = s.dinS1;

    // Register writes; address and data are taken together.
    if (s.wRdy && s_axi_awvalid && s_axi_wvalid)
    begin
      n.bValid = 1'b1;
      n.bResp = nmcs_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        nmcs_pkg::OFF_UPPER:
        begin
          for (int b = 0; b < 4; b++)
            if (s_axi_wstrb[b])
              n.upper[b*8 +: 8] = s_axi_wdata[b*8 +: 8];
          if (s.bytesM1 > nmcs_pkg::BYTES_BASE)
          begin
            n.wrWait = 1'b1;
            n.wrIsData = 1'b0;
          end
        end
        nmcs_pkg::OFF_WRITE:
        begin
          n.wrWait = 1'b1;
          n.wrIsData = 1'b1;
          n.wrData = s_axi_wdata[15:0];
        end
        nmcs_pkg::OFF_CTRL:
        begin
          if (s_axi_wstrb[0])
            n.bytesM1 = s_axi_wdata[2:0];
          if (s_axi_wstrb[1])
          begin
            n.wide = s_axi_wdata[nmcs_pkg::CTRL_WIDE];
            n.eccSimple = s_axi_wdata[nmcs_pkg::CTRL_ECC];
          end
        end
        nmcs_pkg::OFF_IRQST:
          n.irqSt = s.irqSt & ~s_axi_wdata[NUM_EV_W-1:0];
        nmcs_pkg::OFF_IRQMASK:
          n.irqMask = s_axi_wdata[NUM_EV_W-1:0];
        nmcs_pkg::OFF_READ, nmcs_pkg::OFF_STATUS: ;
        default:
          n.bResp = nmcs_pkg::RESP_SLVERR;
      endcase
    end

    // Register reads; the read port answers after its cycle.
    if (s.arRdy && s_axi_arvalid)
    begin
      n.rValid = 1'b1;
      n.rResp = nmcs_pkg::RESP_OKAY;
      n.rData = 32'h0000_0000;
      if (s_axi_araddr[7:4] == nmcs_pkg::OFF_RES_HI)
        n.rData = {5'h00, s.result[{s_axi_araddr[3:2], 1'b1}],
                   5'h00, s.result[{s_axi_araddr[3:2], 1'b0}]};
      else
        case (s_axi_araddr)
          nmcs_pkg::OFF_UPPER:
            n.rData = s.upper;
          nmcs_pkg::OFF_READ:
          begin
            n.rValid = 1'b0;
            n.rdWait = 1'b1;
          end
          nmcs_pkg::OFF_STATUS:
          begin
            n.rData[15:8] = s.uncor;
            n.rData[7:0] = s.corr;
            n.rData[nmcs_pkg::ST_WR_PEND] = (s.op == nmcs_pkg::OP_WR)
              || (s.wrWait && s.wrIsData);
            n.rData[nmcs_pkg::ST_ADDR_PEND] =
              (s.op == nmcs_pkg::OP_ADDR)
              || (s.wrWait && !s.wrIsData);
            n.rData[nmcs_pkg::ST_CMD_PEND] =
              (s.op == nmcs_pkg::OP_CMD);
          end
          nmcs_pkg::OFF_CTRL:
          begin
            n.rData[2:0] = s.bytesM1;
            n.rData[nmcs_pkg::CTRL_WIDE] = s.wide;
            n.rData[nmcs_pkg::CTRL_ECC] = s.eccSimple;
          end
          nmcs_pkg::OFF_IRQST:
            n.rData[NUM_EV_W-1:0] = s.irqSt;
          nmcs_pkg::OFF_IRQMASK:
            n.rData[NUM_EV_W-1:0] = s.irqMask;
          default:
            n.rResp = nmcs_pkg::RESP_SLVERR;
        endcase
    end

    // Capture of the base address and command from the core.
    if (baseAddrWrite)
      n.base = baseAddr;
    if (cmdLaunch)
      n.cmd = cmdByte;

    // Per-block ECC flags and results; a new page clears the flags.
    if (eccPageStart)
    begin
      n.uncor = 8'h00;
      n.corr = 8'h00;
    end
    if (eccBlockDone && s.eccSimple)
    begin
      n.uncor[eccBlockIdx] = eccUncorrectable;
      n.corr[eccBlockIdx] = eccCorrectable;
      n.result[eccBlockIdx] = {eccErrBit, eccErrByte};
      evt[nmcs_pkg::EV_ECC] = eccUncorrectable;
    end

    // Sequencer start; a waiting read goes first.
    if (s.op == nmcs_pkg::OP_IDLE)
    begin
      if (s.rdWait)
      begin
        go = 1'b1;
        goOp = nmcs_pkg::OP_RD;
        n.rdWait = 1'b0;
        n.rdBusy = 1'b1;
      end
      else if (s.wrWait)
      begin
        go = 1'b1;
        n.wrWait = 1'b0;
        goOp = s.wrIsData ? nmcs_pkg::OP_WR : nmcs_pkg::OP_ADDR;
        goVal = s.wrIsData ? s.wrData
                           : {8'h00, nmcs_byte({s.upper, s.base},
                                               3'h0)};
      end
      else if (cmdLaunch)
      begin
        go = 1'b1;
        goOp = nmcs_pkg::OP_CMD;
        goVal = {8'h00, cmdByte};
      end
      else if (baseAddrWrite && s.bytesM1 <= nmcs_pkg::BYTES_BASE)
      begin
        go = 1'b1;
        goOp = nmcs_pkg::OP_ADDR;
        goVal = {8'h00, baseAddr[7:0]};
      end
    end
    else if (s.cnt != 4'h0)
      n.cnt = s.cnt - 4'h1;
    else if (s.strobe)
    begin
      // End of the strobe: release it and start the gap.
      n.strobe = 1'b0;
      n.weN = 1'b1;
      n.reN = 1'b1;
      n.cnt = nmcs_pkg::HOLD_CYC - 4'h1;
    end
    else if (s.op == nmcs_pkg::OP_ADDR && s.idx != s.bytesM1)
    begin
      // Next byte of the address series.
      n.idx = s.idx + 3'h1;
      n.strobe = 1'b1;
      n.weN = 1'b0;
      n.cnt = nmcs_pkg::PULSE_CYC - 4'h1;
      n.dout = {8'h00, nmcs_byte({s.upper, s.base}, n.idx)};
    end
    else
    begin
      // Cycle complete: pending bit drops, event raised.
      n.op = nmcs_pkg::OP_IDLE;
      n.cle = 1'b0;
      n.ale = 1'b0;
      n.doe = 1'b0;
      n.dout = 16'h0000;
      evt[nmcs_pkg::EV_CMD] = (s.op == nmcs_pkg::OP_CMD);
      evt[nmcs_pkg::EV_ADDR] = (s.op == nmcs_pkg::OP_ADDR);
      evt[nmcs_pkg::EV_WR] = (s.op == nmcs_pkg::OP_WR);
      evt[nmcs_pkg::EV_RD] = (s.op == nmcs_pkg::OP_RD);
      // The pin synchroniser lags two edges, so read data is taken
      // after the strobe, when it shows the level seen under it.
      if (s.op == nmcs_pkg::OP_RD)
      begin
        n.rValid = 1'b1;
        n.rResp = nmcs_pkg::RESP_OKAY;
        n.rdBusy = 1'b0;
        n.rData = {16'h0000, s.wide ? s.dinS2[15:8] : 8'h00,
                   s.dinS2[7:0]};
      end
    end

    // Common strobe setup for a newly started cycle.
    if (go)
    begin
      n.op = goOp;
      n.strobe = 1'b1;
      n.idx = 3'h0;
      n.cnt = nmcs_pkg::PULSE_CYC - 4'h1;
      n.cle = (goOp == nmcs_pkg::OP_CMD);
      n.ale = (goOp == nmcs_pkg::OP_ADDR);
      n.weN = (goOp == nmcs_pkg::OP_RD);
      n.reN = (goOp != nmcs_pkg::OP_RD);
      n.doe = (goOp != nmcs_pkg::OP_RD);
      n.dout = s.wide ? goVal : {8'h00, goVal[7:0]};
    end

    // Sticky events win over a clear in the same cycle.
    n.irqSt = n.irqSt | evt;
    n.irq = |(n.irqSt & n.irqMask);
    n.wRdy = !n.bValid && !n.wrWait;
    n.arRdy = !n.rValid && !n.rdWait && !n.rdBusy;
  end

  // ==========================================================
  // State register.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s <= RST_STATE;
    else
      s <= n;
  end

  // Outputs straight from the state register.
  assign s_axi_awready = s.wRdy;
  assign s_axi_wready  = s.wRdy;
  assign s_axi_bvalid  = s.bValid;
  assign s_axi_bresp   = s.bResp;
  assign s_axi_arready = s.arRdy;
  assign s_axi_rvalid  = s.rValid;
  assign s_axi_rresp   = s.rResp;
  assign s_axi_rdata   = s.rData;
  assign flashCle      = s.cle;
  assign flashAle      = s.ale;
  assign flashWeN      = s.weN;
  assign flashReN      = s.reN;
  assign flashDataOut  = s.dout;
  assign flashDataOe   = s.doe;
  assign irq           = s.irq;
endmodule : nmcs_top

// ==== tb/nmcs_assertions.sv ====
// Checker of the manual flash cycles, bound to every nmcs_top.
// Assumes only the top's ports, one clock and a synchronous reset.
module nmcs_assertions (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        flashCle,
  input wire logic        flashAle,
  input wire logic        flashWeN,
  input wire logic        flashReN,
  input wire logic [15:0] flashDataOut,
  input wire logic        flashDataOe
);
  logic [15:0] wrData_q;
  logic        rdPort_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Helper state
  // Remembers the last single-write word and whether a read hit the port.
  always_ff @(posedge clk)
  begin
    if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_awaddr == nmcs_pkg::OFF_WRITE)
      wrData_q <= s_axi_wdata[15:0];
    if (s_axi_arvalid && s_axi_arready)
      rdPort_q <= (s_axi_araddr == nmcs_pkg::OFF_READ);
  end
  // ==========================================================
  // Sequences and properties
  sequence s_wTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid;
  endsequence
  sequence s_lowTwo(sig);
    !sig ##1 sig;
  endsequence
  property p_bAnswer; s_wTake |=> s_axi_bvalid; endproperty
  property p_slvErr;
    s_wTake ##0 (s_axi_awaddr == 8'h10) |=>
      s_axi_bresp == nmcs_pkg::RESP_SLVERR;
  endproperty
  property p_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rdStrobe;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == nmcs_pkg::OFF_READ
      |-> ##[1:40] !flashReN;
  endproperty
  property p_rdUpper;
    s_axi_rvalid && rdPort_q |-> s_axi_rdata[31:16] == 16'h0;
  endproperty
  property p_wrStrobe;
    s_wTake ##0 (s_axi_awaddr == nmcs_pkg::OFF_WRITE) |->
      ##[1:40] (!flashWeN && flashDataOe && !flashCle && !flashAle);
  endproperty
  property p_wrData;
    !flashWeN && flashDataOe && !flashCle && !flashAle |->
      flashDataOut[7:0] == wrData_q[7:0];
  endproperty
  property p_wePulse; $fell(flashWeN) |=> s_lowTwo(flashWeN); endproperty
  property p_rePulse; $fell(flashReN) |=> s_lowTwo(flashReN); endproperty
  property p_readQuiet; !flashReN |-> flashWeN && !flashDataOe;
  endproperty
  a_bAnswer: assert property (p_bAnswer)
    else $error("write response late");
  a_slvErr: assert property (p_slvErr)
    else $error("unmapped write not refused");
  a_refuse: assert property (p_refuse)
    else $error("write taken during response");
  a_rdStrobe: assert property (p_rdStrobe)
    else $error("read port ran no read strobe");
  a_rdUpper: assert property (p_rdUpper)
    else $error("read port upper half not zero");
  a_wrStrobe: assert property (p_wrStrobe)
    else $error("write port ran no write strobe");
  a_wrData: assert property (p_wrData)
    else $error("write strobe carries wrong data");
  a_wePulse: assert property (p_wePulse)
    else $error("write strobe width wrong");
  a_rePulse: assert property (p_rePulse)
    else $error("read strobe width wrong");
  a_readQuiet: assert property (p_readQuiet)
    else $error("pins driven during read");
endmodule : nmcs_assertions

bind nmcs_top nmcs_assertions nmcs_assertions_inst (.clk, .sys_rst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .flashCle, .flashAle, .flashWeN, .flashReN,
  .flashDataOut, .flashDataOe);

// ==== tb/nmcs_flash_model.sv ====
// Behavioural flash device facing the manual-cycle block.
// Assumes active-low strobes; writes are latched on the rising strobe.
module nmcs_flash_model (
  input  wire logic [15:0] flashDataOut,
  input  wire logic        flashCle,
  input  wire logic        flashAle,
  input  wire logic        flashWeN,
  input  wire logic        flashReN,
  input  wire logic        flashDataOe,
  output logic      [15:0] flashDataIn,
  input  wire logic [15:0] readValue,
  input  wire logic        slowMode,
  output logic      [7:0]  lastCmd,
  output logic      [15:0] lastWrite,
  output logic      [63:0] addrLog,
  output int               addrCount
);
  timeunit 1ns;
  timeprecision 100ps;
  // Start with empty logs.
  initial
  begin
    {flashDataIn, lastCmd, lastWrite, addrLog} = '0;
    addrCount = 0;
  end
  // Latch command, address byte or data word on the rising strobe.
  always @(posedge flashWeN)
  begin
    if (flashDataOe && flashCle)
      lastCmd <= flashDataOut[7:0];
    else if (flashDataOe && flashAle)
    begin
      addrLog   <= {addrLog[55:0], flashDataOut[7:0]};
      addrCount <= addrCount + 1;
    end
    else if (flashDataOe)
      lastWrite <= flashDataOut;
  end
  // Answer a read promptly or slowly; once released the lines invert.
  always @(negedge flashReN)
    flashDataIn <= #(slowMode ? 15 : 3) readValue;
  always @(posedge flashReN)
    flashDataIn <= #10 ~readValue;
endmodule : nmcs_flash_model

// ==== tb/nand_manual_cycle_status_test.sv ====
// Self-checking bench of nmcs_top with a flash model on its pins.
// Assumes the package offsets and a 40 MHz clock.
module nand_manual_cycle_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, cmdLaunch, baseAddrWrite;
  logic eccPageStart, eccBlockDone, eccCorrectable, eccUncorrectable;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, flashCle, flashAle, flashWeN, flashReN;
  logic flashDataOe, irq, slowMode;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  eccBlockIdx, eccErrBit;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, cmdByte, eccErrByte, lastCmd;
  logic [15:0] flashDataOut, flashDataIn, readValue, lastWrite;
  logic [31:0] s_axi_wdata, s_axi_rdata, baseAddr, d, v, u;
  logic [63:0] addrLog;
  int          addrCount, mismatches, comparisons, cor[8], unc[8], res[8];
  nmcs_top nmcs_top_inst (.*);
  nmcs_flash_model nmcs_flash_model_inst (.*);
  // 40 MHz clock.
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] dt,
                     input logic [3:0] s, output logic [1:0] rs);
    int n;
    s_axi_awaddr <= a; s_axi_wdata <= dt; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk);
      if (s_axi_awready === 1) s_axi_awvalid <= 0;
      if (s_axi_awready === 1) s_axi_wvalid <= 0;
      if (s_axi_bvalid === 1) break;
    end
    rs = s_axi_bresp;
    if (n == 200) begin mismatches++; report_and_stop(); end
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] dt);
    int n;
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk);
      if (s_axi_arready === 1) s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1) break;
    end
    dt = s_axi_rdata;
    if (n == 200) begin mismatches++; report_and_stop(); end
    chk("rresp", s_axi_rresp, 2'h0);
  endtask : axr
  // Polls one pending bit until it clears.
  task automatic pend(input int b);
    int n;
    for (n = 0; n < 60; n++)
    begin
      axr(nmcs_pkg::OFF_STATUS, d);
      if (d[b] === 1'b0) break;
    end
    if (n == 60) begin mismatches++; report_and_stop(); end
  endtask : pend
  // Writes a launching register and reads status one cycle behind it.
  task automatic peek(input logic [7:0] a, input logic [31:0] dt, int b);
    fork
      axw(a, dt, 4'hf, r);
      begin @(posedge clk); axr(nmcs_pkg::OFF_STATUS, d); end
    join
    chk("pending", d[b], 1);
    pend(b);
  endtask : peek
  // ==========================================================
  // Main sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cmdLaunch} = '0;
    {baseAddrWrite, eccPageStart, eccBlockDone, slowMode} = '0;
    {eccCorrectable, eccUncorrectable, eccBlockIdx, eccErrBit} = '0;
    {s_axi_awaddr, s_axi_araddr, cmdByte, eccErrByte, readValue} = '0;
    {s_axi_wdata, baseAddr, s_axi_wstrb} = '0;
    {s_axi_bready, s_axi_rready, sys_rst} = 3'h7;
    mismatches = 0; comparisons = 0;
    v = $urandom(94);
    repeat (12) @(posedge clk);
    sys_rst <= 0;
    repeat (2) @(posedge clk);
    axr(nmcs_pkg::OFF_UPPER, d); chk("upper", d, 0);
    axr(nmcs_pkg::OFF_STATUS, d); chk("status", d, 0);
    axr(nmcs_pkg::OFF_IRQMASK, d); chk("mask", d, 0);
    axw(8'h10, 32'hffff_ffff, 4'hf, r); chk("unmapped", r, 2'h2);
    axw(nmcs_pkg::OFF_READ, 32'h1, 4'hf, r); chk("ro", r, 2'h0);
    $display("test registers done");
    u = $urandom; cmdByte <= u[7:0]; cmdLaunch <= 1;
    @(posedge clk); cmdLaunch <= 0;
    pend(16); chk("command", lastCmd, u[7:0]);
    baseAddr <= $urandom; baseAddrWrite <= 1;
    @(posedge clk); baseAddrWrite <= 0;
    pend(17); chk("no address", addrCount, 0);
    u = $urandom; peek(nmcs_pkg::OFF_UPPER, u, 17);
    axr(nmcs_pkg::OFF_UPPER, d); chk("upper", d, u);
    chk("count", addrCount, 5);
    chk("bytes", addrLog[39:0], {baseAddr[7:0], baseAddr[15:8],
      baseAddr[23:16], baseAddr[31:24], u[7:0]});
    $display("test address done");
    for (int m = 0; m < 2; m++)
    begin
      v = $urandom; readValue <= v[15:0]; slowMode <= m[0];
      axr(nmcs_pkg::OFF_READ, d);
      chk("read", d, m ? v[15:0] : v[7:0]);
      axw(nmcs_pkg::OFF_CTRL, 32'h300, 4'h2, r);
    end
    u = $urandom; peek(nmcs_pkg::OFF_WRITE, u, 18);
    chk("write", lastWrite, u[15:0]);
    axr(nmcs_pkg::OFF_IRQST, d); chk("events", d, 32'hf);
    axw(nmcs_pkg::OFF_IRQST, 32'h1f, 4'hf, r);
    axw(nmcs_pkg::OFF_IRQMASK, 32'h10, 4'hf, r);
    $display("test cycles done");
    eccPageStart <= 1; @(posedge clk); eccPageStart <= 0;
    for (int k = 0; k < 9; k++)
    begin
      v = $urandom | (k == 7 ? 2 : 0);
      eccBlockIdx <= k[2:0]; eccCorrectable <= v[0];
      eccUncorrectable <= v[1]; eccErrByte <= v[15:8];
      eccErrBit <= v[18:16]; eccBlockDone <= 1;
      @(posedge clk); eccBlockDone <= 0; @(posedge clk);
      if (k == 7) axw(nmcs_pkg::OFF_CTRL, 32'h100, 4'h2, r);
      if (k < 8) cor[k] = v[0];
      if (k < 8) unc[k] = v[1];
      if (k < 8) res[k] = v[18:8];
      u = 0;
      for (int j = 0; j < 8; j++) u[j] = cor[j][0];
      for (int j = 0; j < 8; j++) u[j+8] = unc[j][0];
      axr(nmcs_pkg::OFF_STATUS, d); chk("flags", d, u);
    end
    for (int k = 0; k < 4; k++)
    begin
      u = {5'h0, res[2*k+1][10:0], 5'h0, res[2*k][10:0]};
      v = {{16{cor[2*k+1][0]}}, {16{cor[2*k][0]}}};
      axr(8'h30 + 8'(4*k), d); chk("result", d & v, u & v);
    end
    axr(nmcs_pkg::OFF_IRQST, d); chk("irq", {d, irq}, 33'h21);
    axw(nmcs_pkg::OFF_IRQMASK, 32'h0, 4'hf, r);
    axr(nmcs_pkg::OFF_IRQST, d); chk("irq", {d, irq}, 33'h20);
    axw(nmcs_pkg::OFF_IRQMASK, 32'h10, 4'hf, r);
    axr(nmcs_pkg::OFF_IRQST, d); chk("irq", {d, irq}, 33'h21);
    axw(nmcs_pkg::OFF_IRQST, 32'h10, 4'hf, r);
    axr(nmcs_pkg::OFF_IRQST, d); chk("irq", {d, irq}, 33'h0);
    $display("test ecc done");
    report_and_stop();
  end
endmodule : nand_manual_cycle_status_test
